//--- sctf_pkg.sv
// shared constants for the secure chain telegram framer
package sctf_pkg;
	// ----------------------------------------------------------------
	// telegram codes
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_WRAP_CODE = 8'ha6;
	localparam logic [7:0] SEC_CHAIN_CODE = 8'h33;
	// ----------------------------------------------------------------
	// widths and field sizes
	// ----------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int RLC_W = 32;
	localparam int IDX_W = 6;
	localparam int CHAIN_ID_W = 2;
	localparam int WINDOW_W = 4;
	localparam int FIFO_DEPTH = 8;
	localparam logic [7:0] NODE_ID_BYTES = 8'h04;
	localparam logic [7:0] LEN_FIELD_BYTES = 8'h02;
	localparam logic [7:0] FIELD_LONG_BYTES = 8'h04;
	localparam logic [7:0] FIELD_SHORT_BYTES = 8'h03;
	// payload room per segment once wrapped with the destination
	localparam logic [7:0] FIRST_DATA_MAX = 8'h05;
	localparam logic [7:0] MID_DATA_MAX = 8'h08;
	localparam logic [7:0] LAST_MAX_LONG = 8'h05;
	localparam logic [7:0] LAST_MAX_SHORT = 8'h07;
	localparam logic [23:0] SHORT_MASK = 24'hffffff;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [RLC_W-1:0] RLC_RESET = 32'h0000_0000;
	localparam logic [IDX_W-1:0] IDX_RESET = 6'h00;
endpackage : sctf_pkg

//--- sctf_fifo.sv
// payload byte fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sctf_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_clk_en,
	// fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	// drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	// extra pointer bit tells full from empty
	assign o_in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
	assign o_out_valid = wr_q != rd_q;
	assign o_out_data = mem[rd_q[AW-1:0]];
	assign push = i_clk_en && i_in_valid && o_in_ready;
	assign pop = i_clk_en && o_out_valid && i_out_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule : sctf_fifo
`default_nettype wire

//--- sctf_top.sv
// secure chain telegram framer: addressed chain builder and signature/replay checker
//
// Overview of operation
// - Each segment opens with the addressed-wrapper code, then the secure chain code; destination id precedes sender id.
// - The chain control byte holds a 2-bit chain id and a 6-bit segment index counting up from zero, 63 at most.
// - Intermediary segments drop the length and type fields but keep both 4-byte ids, the status byte and the check byte.
// - The last segment carries 0 to 7 payload bytes, a 3 or 4 byte signature, then a 3 or 4 byte rolling code, then the ids.
// - The secure chain is laid out first and each segment is then wrapped with the wrapper code and destination id.
// - A final segment that overflows once wrapped is split into an intermediary and a final addressed segment.
// - The computed signature travels in the same telegram as the content.
// - The receiver recomputes the signature and accepts only when it equals the received one.
// - The receiver stores the last accepted rolling code and rejects any code not later than it.
// - The rolling code is a counter that steps by one per transmitted message at the sender; the receiver jumps to each accepted code.
// - The current rolling code feeds the initialization vector used with the key.
// - One shared symmetric key serves both encryption and decryption; no public key scheme exists here.
// - On a signature miss with an implicit code the receiver tries successive future codes up to the window and stores a match.
`timescale 1ns/1ps
`default_nettype none
module sctf_top
	import sctf_pkg::*;
(
	// clock, reset, enable
	input wire logic I_CORE_CLK,
	input wire logic I_ARST_N,
	input wire logic I_CLK_EN,
	// chain request
	input wire logic I_TX_START,
	output logic O_TX_START_READY,
	input wire logic [7:0] I_TX_LEN,
	input wire logic [CHAIN_ID_W-1:0] I_TX_CHAIN_ID,
	input wire logic [7:0] I_TX_RADIO_TELEGRAM_TYPE,
	input wire logic [31:0] I_DEST_NODE_ID,
	input wire logic [31:0] I_SRC_NODE_ID,
	input wire logic [7:0] I_TX_STATUS,
	input wire logic I_SHORT_FIELDS,
	// payload in
	input wire logic I_PAY_VALID,
	output logic O_PAY_READY,
	input wire logic [7:0] I_PAY_DATA,
	// telegram byte stream out
	output logic O_TX_VALID,
	input wire logic I_TX_READY,
	output logic [7:0] O_TX_DATA,
	output logic O_TX_FIRST,
	output logic O_TX_LAST,
	output logic O_TX_DONE,
	// rolling codes
	input wire logic I_RLC_LOAD,
	input wire logic [RLC_W-1:0] I_RLC_TX_INIT,
	input wire logic [RLC_W-1:0] I_RLC_RX_INIT,
	output logic [RLC_W-1:0] O_TX_ROLLING_CODE,
	output logic [RLC_W-1:0] O_RX_ROLLING_CODE,
	// signature engine (holds the shared key)
	output logic O_SIG_REQ,
	output logic [RLC_W-1:0] O_SIG_IV,
	input wire logic I_SIG_VALID,
	input wire logic [31:0] I_SIG_VALUE,
	// receive check
	input wire logic I_RX_CHECK,
	output logic O_RX_READY,
	input wire logic [31:0] I_RX_SIG,
	input wire logic I_RX_RLC_EXPLICIT,
	input wire logic [RLC_W-1:0] I_RX_RLC,
	input wire logic [WINDOW_W-1:0] I_RLC_WINDOW,
	output logic O_RX_AUTH_OK,
	output logic O_RX_AUTH_FAIL,
	output logic O_RX_REPLAY
);
	// ----------------------------------------------------------------
	// types and helpers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TX_IDLE, TX_SIG, TX_RUN} sctf_tx_t;
	typedef enum logic {RX_IDLE, RX_WAIT} sctf_rx_t;
	typedef enum logic [3:0] {F_WRAP, F_TYPE, F_CTRL, F_LEN, F_RADIO_TELEGRAM_TYPE, F_DATA,
		F_SIG, F_RLC, F_DEST, F_SRC, F_STAT, F_CHK} sctf_fld_t;

	// short mode keeps 24 bits of codes and signatures
	function automatic logic [31:0] rlc_mask(input logic [31:0] v, input logic short_m);
		rlc_mask = short_m ? {8'h00, v[23:0] & SHORT_MASK} : v;
	endfunction : rlc_mask

	function automatic logic [7:0] pick(input logic [31:0] w, input logic [7:0] k);
		logic [31:0] s;
		s = w >> {k[1:0], 3'b000};
		pick = s[7:0];
	endfunction : pick

	sctf_tx_t tx_st_q;
	sctf_rx_t rx_st_q;
	sctf_fld_t fld_q, fld_d;
	logic [7:0] cnt_q, flen, byte_d, rem_q, seg_n_q, len_q, radio_telegram_type_q, stat_q, chk_q;
	logic [7:0] cap, last_max, plan_n, fn;
	logic [IDX_W-1:0] idx_q;
	logic [CHAIN_ID_W-1:0] cid_q;
	logic [31:0] dest_q, src_q, sig_q, rsig_q;
	logic [RLC_W-1:0] tx_rlc_q, rx_rlc_q, cand_q, rx_iv;
	logic [WINDOW_W-1:0] tries_q;
	logic short_q, last_q, plan_last, out_v_q, first_q, lastb_q, done_q;
	logic ok_q, fail_q, replay_q, sig_req_q;
	logic [7:0] out_q;
	logic [RLC_W-1:0] iv_q;
	logic fifo_v, load, fld_end, start_ok, rx_go, rx_bad, tx_sig_go, rx_sig_go, sig_hit;
	logic [7:0] fifo_d;

	// ----------------------------------------------------------------
	// payload fifo
	// ----------------------------------------------------------------
	sctf_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk(I_CORE_CLK),
		.i_arst_n(I_ARST_N),
		.i_clk_en(I_CLK_EN),
		.i_in_valid(I_PAY_VALID),
		.o_in_ready(O_PAY_READY),
		.i_in_data(I_PAY_DATA),
		.o_out_valid(fifo_v),
		.i_out_ready(load && fld_q == F_DATA),
		.o_out_data(fifo_d)
	);

	// ----------------------------------------------------------------
	// request acceptance
	// ----------------------------------------------------------------
	// only one of transmit and check owns the signature engine at a time
	// hold off a new chain while the rolling code steps, so the next chain never reuses the old code
	assign O_TX_START_READY = tx_st_q == TX_IDLE && rx_st_q == RX_IDLE && !done_q;
	assign O_RX_READY = O_TX_START_READY;
	assign start_ok = I_CLK_EN && I_TX_START && O_TX_START_READY;
	assign rx_go = I_CLK_EN && I_RX_CHECK && O_RX_READY && !I_TX_START;
	assign rx_bad = I_RX_RLC_EXPLICIT && rlc_mask(I_RX_RLC, I_SHORT_FIELDS) <= rx_rlc_q;

	// ----------------------------------------------------------------
	// segment planning
	// ----------------------------------------------------------------
	assign fn = short_q ? FIELD_SHORT_BYTES : FIELD_LONG_BYTES;
	assign cap = (idx_q == IDX_RESET) ? FIRST_DATA_MAX : MID_DATA_MAX;
	assign last_max = short_q ? LAST_MAX_SHORT : LAST_MAX_LONG;
	// an overflowing remainder goes out as one more intermediary first
	assign plan_last = idx_q != IDX_RESET && rem_q <= last_max;
	assign plan_n = (plan_last || rem_q < cap) ? rem_q : cap;

	always_comb begin
		byte_d = 8'h00;
		flen = 8'h01;
		fld_d = fld_q;
		unique case (fld_q)
			F_WRAP: begin
				byte_d = ADDR_WRAP_CODE;
				fld_d = F_TYPE;
			end
			F_TYPE: begin
				byte_d = SEC_CHAIN_CODE;
				fld_d = F_CTRL;
			end
			F_CTRL: begin
				byte_d = {cid_q, idx_q};
				if (idx_q == IDX_RESET) begin
					fld_d = F_LEN;
				end else if (seg_n_q != 8'h00) begin
					fld_d = F_DATA;
				end else begin
					fld_d = last_q ? F_SIG : F_DEST;
				end
			end
			F_LEN: begin
				byte_d = (cnt_q == 8'h00) ? 8'h00 : len_q;
				flen = LEN_FIELD_BYTES;
				fld_d = F_RADIO_TELEGRAM_TYPE;
			end
			F_RADIO_TELEGRAM_TYPE: begin
				byte_d = radio_telegram_type_q;
				fld_d = (seg_n_q != 8'h00) ? F_DATA : F_DEST;
			end
			F_DATA: begin
				byte_d = fifo_d;
				flen = seg_n_q;
				fld_d = last_q ? F_SIG : F_DEST;
			end
			F_SIG: begin
				byte_d = pick(sig_q, fn - 8'h01 - cnt_q);
				flen = fn;
				fld_d = F_RLC;
			end
			F_RLC: begin
				byte_d = pick(tx_rlc_q, fn - 8'h01 - cnt_q);
				flen = fn;
				fld_d = F_DEST;
			end
			F_DEST: begin
				byte_d = pick(dest_q, NODE_ID_BYTES - 8'h01 - cnt_q);
				flen = NODE_ID_BYTES;
				fld_d = F_SRC;
			end
			F_SRC: begin
				byte_d = pick(src_q, NODE_ID_BYTES - 8'h01 - cnt_q);
				flen = NODE_ID_BYTES;
				fld_d = F_STAT;
			end
			F_STAT: begin
				byte_d = stat_q;
				fld_d = F_CHK;
			end
			F_CHK: begin
				byte_d = chk_q;
				fld_d = F_WRAP;
			end
			default: begin
				fld_d = F_WRAP;
			end
		endcase
	end

	assign fld_end = cnt_q == flen - 8'h01;
	// a starved payload fifo stalls the stream rather than padding it
	assign load = I_CLK_EN && tx_st_q == TX_RUN && (!out_v_q || I_TX_READY) && !(fld_q == F_DATA && !fifo_v);

	// ----------------------------------------------------------------
	// transmit sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tx_st_q <= TX_IDLE;
		end else if (I_CLK_EN) begin
			if (start_ok) begin
				tx_st_q <= TX_SIG;
			end else if (tx_st_q == TX_SIG && I_SIG_VALID) begin
				tx_st_q <= TX_RUN;
			end else if (load && fld_q == F_CHK && last_q) begin
				tx_st_q <= TX_IDLE;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			fld_q <= F_WRAP;
			cnt_q <= 8'h00;
			idx_q <= IDX_RESET;
			rem_q <= 8'h00;
			seg_n_q <= 8'h00;
			last_q <= 1'b0;
			chk_q <= 8'h00;
		end else if (start_ok) begin
			fld_q <= F_WRAP;
			cnt_q <= 8'h00;
			idx_q <= IDX_RESET;
			rem_q <= I_TX_LEN;
		end else if (load) begin
			fld_q <= fld_end ? fld_d : fld_q;
			cnt_q <= fld_end ? 8'h00 : cnt_q + 8'h01;
			chk_q <= (fld_q == F_WRAP) ? byte_d : chk_q ^ byte_d;
			if (fld_q == F_WRAP) begin
				seg_n_q <= plan_n;
				last_q <= plan_last;
			end
			if (fld_q == F_DATA) begin
				rem_q <= rem_q - 8'h01;
			end
			if (fld_q == F_CHK && !last_q) begin
				idx_q <= idx_q + 1'b1;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			len_q <= 8'h00;
			cid_q <= '0;
			radio_telegram_type_q <= 8'h00;
			dest_q <= 32'h0000_0000;
			src_q <= 32'h0000_0000;
			stat_q <= 8'h00;
			short_q <= 1'b0;
			sig_q <= 32'h0000_0000;
		end else if (I_CLK_EN) begin
			if (start_ok || rx_go) begin
				short_q <= I_SHORT_FIELDS;
			end
			if (start_ok) begin
				len_q <= I_TX_LEN;
				cid_q <= I_TX_CHAIN_ID;
				radio_telegram_type_q <= I_TX_RADIO_TELEGRAM_TYPE;
				dest_q <= I_DEST_NODE_ID;
				src_q <= I_SRC_NODE_ID;
				stat_q <= I_TX_STATUS;
			end
			if (tx_st_q == TX_SIG && I_SIG_VALID) begin
				sig_q <= rlc_mask(I_SIG_VALUE, short_q);
			end
		end
	end

	// registered output byte stage
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			out_v_q <= 1'b0;
			out_q <= 8'h00;
			first_q <= 1'b0;
			lastb_q <= 1'b0;
			done_q <= 1'b0;
		end else if (I_CLK_EN) begin
			done_q <= load && fld_q == F_CHK && last_q;
			if (load) begin
				out_v_q <= 1'b1;
				out_q <= byte_d;
				first_q <= fld_q == F_WRAP;
				lastb_q <= fld_q == F_CHK;
			end else if (I_TX_READY) begin
				out_v_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// rolling codes
	// ----------------------------------------------------------------
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tx_rlc_q <= RLC_RESET;
		end else if (I_CLK_EN) begin
			if (I_RLC_LOAD) begin
				tx_rlc_q <= I_RLC_TX_INIT;
			end else if (done_q) begin
				tx_rlc_q <= rlc_mask(tx_rlc_q + 32'h1, short_q);
			end
		end
	end

	// ----------------------------------------------------------------
	// receive check with rolling code window
	// ----------------------------------------------------------------
	// the engine holds the single symmetric key for both directions
	assign sig_hit = rlc_mask(I_SIG_VALUE, short_q) == rlc_mask(rsig_q, short_q);
	assign tx_sig_go = start_ok;
	assign rx_sig_go = (rx_go && !rx_bad) || (rx_st_q == RX_WAIT && I_SIG_VALID && !sig_hit && tries_q > 4'h1);
	assign rx_iv = (rx_st_q == RX_WAIT) ? rlc_mask(cand_q + 32'h1, short_q)
		: I_RX_RLC_EXPLICIT ? rlc_mask(I_RX_RLC, I_SHORT_FIELDS) : rlc_mask(rx_rlc_q + 32'h1, I_SHORT_FIELDS);

	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rx_st_q <= RX_IDLE;
			cand_q <= RLC_RESET;
			tries_q <= '0;
			rsig_q <= 32'h0000_0000;
			ok_q <= 1'b0;
			fail_q <= 1'b0;
			replay_q <= 1'b0;
		end else if (I_CLK_EN) begin
			ok_q <= 1'b0;
			fail_q <= 1'b0;
			replay_q <= 1'b0;
			if (rx_go && rx_bad) begin
				fail_q <= 1'b1;
				replay_q <= 1'b1;
			end else if (rx_go) begin
				rx_st_q <= RX_WAIT;
				cand_q <= rx_iv;
				rsig_q <= I_RX_SIG;
				tries_q <= (I_RX_RLC_EXPLICIT || I_RLC_WINDOW == '0) ? 4'h1 : I_RLC_WINDOW;
			end else if (rx_st_q == RX_WAIT && I_SIG_VALID) begin
				if (sig_hit) begin
					ok_q <= 1'b1;
					rx_st_q <= RX_IDLE;
				end else if (tries_q > 4'h1) begin
					cand_q <= rx_iv;
					tries_q <= tries_q - 4'h1;
				end else begin
					fail_q <= 1'b1;
					rx_st_q <= RX_IDLE;
				end
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rx_rlc_q <= RLC_RESET;
		end else if (I_CLK_EN) begin
			if (I_RLC_LOAD) begin
				rx_rlc_q <= I_RLC_RX_INIT;
			end else if (rx_st_q == RX_WAIT && I_SIG_VALID && sig_hit) begin
				rx_rlc_q <= cand_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// signature engine request
	// ----------------------------------------------------------------
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			sig_req_q <= 1'b0;
			iv_q <= RLC_RESET;
		end else if (I_CLK_EN) begin
			if (tx_sig_go) begin
				sig_req_q <= 1'b1;
				iv_q <= tx_rlc_q;
			end else if (rx_sig_go) begin
				sig_req_q <= 1'b1;
				iv_q <= rx_iv;
			end else if (I_SIG_VALID) begin
				sig_req_q <= 1'b0;
			end
		end
	end

	assign O_TX_VALID = out_v_q;
	assign O_TX_DATA = out_q;
	assign O_TX_FIRST = first_q;
	assign O_TX_LAST = lastb_q;
	assign O_TX_DONE = done_q;
	assign O_TX_ROLLING_CODE = tx_rlc_q;
	assign O_RX_ROLLING_CODE = rx_rlc_q;
	assign O_SIG_REQ = sig_req_q;
	assign O_SIG_IV = iv_q;
	assign O_RX_AUTH_OK = ok_q;
	assign O_RX_AUTH_FAIL = fail_q;
	assign O_RX_REPLAY = replay_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [7:0] pos_q, acc_q;
	logic [IDX_W-1:0] seg_cnt_q;
	logic acc_ok;
	assign acc_ok = I_CLK_EN && out_v_q && I_TX_READY;
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pos_q <= 8'h00;
			acc_q <= 8'h00;
			seg_cnt_q <= IDX_RESET;
		end else begin
			if (start_ok) begin
				seg_cnt_q <= IDX_RESET;
			end else if (acc_ok && lastb_q) begin
				seg_cnt_q <= seg_cnt_q + 1'b1;
			end
			if (acc_ok) begin
				pos_q <= lastb_q ? 8'h00 : pos_q + 8'h01;
				acc_q <= first_q ? out_q : acc_q ^ out_q;
			end
		end
	end

	chk_wrap_first: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		out_v_q && pos_q == 8'h00 |-> first_q && out_q == ADDR_WRAP_CODE)
		else $error("segment does not open with wrapper code");
	chk_chain_type: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		out_v_q && pos_q == 8'h01 |-> out_q == SEC_CHAIN_CODE)
		else $error("second byte is not the secure chain code");
	chk_ctrl_index: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		out_v_q && pos_q == 8'h02 |-> out_q[IDX_W-1:0] == seg_cnt_q && out_q[7:6] == cid_q)
		else $error("chain control byte wrong");
	chk_check_byte: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		out_v_q && lastb_q |-> out_q == acc_q)
		else $error("check byte mismatch");
	chk_rlc_step: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		I_CLK_EN && done_q && !I_RLC_LOAD |=> tx_rlc_q == rlc_mask($past(tx_rlc_q) + 32'h1, short_q))
		else $error("transmit rolling code did not step by one");
	chk_iv_source: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		start_ok |=> sig_req_q && iv_q == $past(tx_rlc_q) && tx_st_q == TX_SIG)
		else $error("iv is not the transmit rolling code");
	chk_replay_reject: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		rx_go && rx_bad |=> fail_q && replay_q && rx_st_q == RX_IDLE)
		else $error("stale rolling code not rejected");
	chk_auth_accept: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		I_CLK_EN && rx_st_q == RX_WAIT && I_SIG_VALID && sig_hit && !I_RLC_LOAD |=> ok_q && rx_rlc_q == $past(cand_q))
		else $error("matching signature not accepted");
	chk_fail_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		fail_q && !$past(I_RLC_LOAD) |-> !ok_q && $stable(rx_rlc_q))
		else $error("failure changed stored rolling code");
endmodule : sctf_top
`default_nettype wire

//--- sctf_remote_node.sv
// remote node model: keyed signature engine and telegram byte sink
`timescale 1ns/1ps
`default_nettype none
module sctf_remote_node #(
	parameter logic [31:0] KEY = 32'h1234_abcd
) (
	// clock, reset, pace
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_slow,
	// signature engine
	input wire logic i_sig_req,
	input wire logic [31:0] i_sig_iv,
	output logic o_sig_valid,
	output logic [31:0] o_sig_value,
	// telegram sink
	output logic o_tx_ready
);
	logic [1:0] wait_q;
	logic [2:0] ph_q;
	// one key serves both directions
	function automatic logic [31:0] sign(input logic [31:0] iv);
		return {iv[15:0], iv[31:16]} ^ KEY;
	endfunction : sign
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wait_q <= 2'h0;
			o_sig_valid <= 1'b0;
			o_sig_value <= 32'h0;
		end else if (i_sig_req && !o_sig_valid && wait_q == (i_slow ? 2'h3 : 2'h0)) begin
			o_sig_valid <= 1'b1;
			o_sig_value <= sign(i_sig_iv);
			wait_q <= 2'h0;
		end else begin
			o_sig_valid <= 1'b0;
			// stale data flips so it never passes for a fresh answer
			o_sig_value <= ~o_sig_value;
			wait_q <= (i_sig_req && !o_sig_valid) ? wait_q + 2'h1 : 2'h0;
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ph_q <= 3'h0;
			o_tx_ready <= 1'b0;
		end else begin
			ph_q <= ph_q + 3'h1;
			o_tx_ready <= !i_slow || ph_q[1];
		end
	end
endmodule : sctf_remote_node
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the secure chain telegram framer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sctf_pkg::*;
	localparam logic [31:0] KEY = 32'h1234_abcd;
	logic clk, arst_n, tx_start, short_f, pay_valid, rlc_load, slow, rx_check, rx_expl, tx_ready, sig_valid;
	logic start_rdy, pay_rdy, tx_valid, tx_first, tx_last, tx_done, sig_req, rx_rdy, ok, fail, replay;
	logic [7:0] tx_len, radio_telegram_type, status, pay_data, tx_data;
	logic [CHAIN_ID_W-1:0] chain_id;
	logic [31:0] dest, src, rx_sig, sig_value;
	logic [RLC_W-1:0] rlc_tx_init, rlc_rx_init, rx_rlc, sig_iv, tx_rlc, rx_rlc_q;
	logic [WINDOW_W-1:0] window;
	logic [9:0] got[$];
	logic [9:0] exp_q[$];
	int num_errors = 0;
	int n_tests = 0;
	int n_done = 0;
	sctf_top sctf_top_inst (.I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_CLK_EN(1'b1), .I_TX_START(tx_start),
		.O_TX_START_READY(start_rdy), .I_TX_LEN(tx_len), .I_TX_CHAIN_ID(chain_id), .I_TX_RADIO_TELEGRAM_TYPE(radio_telegram_type),
		.I_DEST_NODE_ID(dest), .I_SRC_NODE_ID(src), .I_TX_STATUS(status), .I_SHORT_FIELDS(short_f),
		.I_PAY_VALID(pay_valid), .O_PAY_READY(pay_rdy), .I_PAY_DATA(pay_data), .O_TX_VALID(tx_valid),
		.I_TX_READY(tx_ready), .O_TX_DATA(tx_data), .O_TX_FIRST(tx_first), .O_TX_LAST(tx_last),
		.O_TX_DONE(tx_done), .I_RLC_LOAD(rlc_load), .I_RLC_TX_INIT(rlc_tx_init), .I_RLC_RX_INIT(rlc_rx_init),
		.O_TX_ROLLING_CODE(tx_rlc), .O_RX_ROLLING_CODE(rx_rlc_q), .O_SIG_REQ(sig_req), .O_SIG_IV(sig_iv),
		.I_SIG_VALID(sig_valid), .I_SIG_VALUE(sig_value), .I_RX_CHECK(rx_check), .O_RX_READY(rx_rdy),
		.I_RX_SIG(rx_sig), .I_RX_RLC_EXPLICIT(rx_expl), .I_RX_RLC(rx_rlc), .I_RLC_WINDOW(window),
		.O_RX_AUTH_OK(ok), .O_RX_AUTH_FAIL(fail), .O_RX_REPLAY(replay));
	sctf_remote_node #(.KEY(KEY)) sctf_remote_node_inst (.i_clk(clk), .i_arst_n(arst_n), .i_slow(slow),
		.i_sig_req(sig_req), .i_sig_iv(sig_iv), .o_sig_valid(sig_valid), .o_sig_value(sig_value),
		.o_tx_ready(tx_ready));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back({tx_first, tx_last, tx_data});
		if (tx_done === 1'b1) n_done++;
	end
	function automatic logic [31:0] sig_f(input logic [31:0] iv);
		return {iv[15:0], iv[31:16]} ^ KEY;
	endfunction : sig_f
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, g, e);
		end
	endtask : check
	task automatic give_up(input string what);
		num_errors++;
		$display("CHECK FAILED at %0t: %s timed out", $time, what);
		end_of_test();
	endtask : give_up
	task automatic wait_ready();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while ((start_rdy !== 1'b1 || rx_rdy !== 1'b1) && k < 3000);
		if (k >= 3000) give_up("idle");
	endtask : wait_ready
	// expected byte stream: {first, last, data} per byte
	task automatic build(input int len, input logic sh, input logic [31:0] rolling_code);
		int rem, n, p, idx, nf;
		bit last;
		logic [7:0] seg[$];
		logic [7:0] x;
		logic [31:0] s;
		rem = len;
		p = 0;
		idx = 0;
		nf = sh ? 3 : 4;
		s = sig_f(rolling_code);
		exp_q.delete();
		do begin
			seg = '{ADDR_WRAP_CODE, SEC_CHAIN_CODE, {chain_id, 6'(idx)}};
			if (idx == 0) seg = {seg, 8'h00, len[7:0], radio_telegram_type};
			last = idx > 0 && rem <= (sh ? 7 : 5);
			n = idx == 0 ? (rem < 5 ? rem : 5) : (last ? rem : (rem < 8 ? rem : 8));
			for (int i = 0; i < n; i++) seg.push_back(8'h40 + 8'(p + i));
			p += n;
			rem -= n;
			for (int i = nf - 1; i >= 0; i--) if (last) seg.push_back(s[8*i +: 8]);
			for (int i = nf - 1; i >= 0; i--) if (last) seg.push_back(rolling_code[8*i +: 8]);
			for (int i = 3; i >= 0; i--) seg.push_back(dest[8*i +: 8]);
			for (int i = 3; i >= 0; i--) seg.push_back(src[8*i +: 8]);
			seg.push_back(status);
			x = 8'h00;
			foreach (seg[i]) x ^= seg[i];
			seg.push_back(x);
			foreach (seg[i]) exp_q.push_back({i == 0, i == seg.size() - 1, seg[i]});
			idx++;
		end while (!last);
	endtask : build
	task automatic feed(input int len);
		int k;
		for (int i = 0; i < len; i++) begin
			pay_valid <= 1'b1;
			pay_data <= 8'h40 + 8'(i);
			k = 0;
			do begin
				@(posedge clk);
				k++;
			end while (pay_rdy !== 1'b1 && k < 500);
			if (k >= 500) give_up("payload");
		end
		pay_valid <= 1'b0;
	endtask : feed
	task automatic t_tx(input int len, input logic sh, input logic slw);
		logic [31:0] r;
		int k, d;
		slow <= slw;
		wait_ready();
		r = tx_rlc;
		d = n_done;
		build(len, sh, r);
		got.delete();
		short_f <= sh;
		tx_len <= len[7:0];
		tx_start <= 1'b1;
		@(posedge clk);
		tx_start <= 1'b0;
		fork
			feed(len);
			for (k = 0; k < 3000 && got.size() < exp_q.size(); k++) @(posedge clk);
		join
		check(got.size(), exp_q.size(), "byte count");
		foreach (exp_q[i]) if (i < got.size()) check(got[i], exp_q[i], "telegram byte");
		repeat (3) @(posedge clk);
		check(tx_rlc, r + 1, "tx code step");
		check(n_done, d + 1, "done pulses");
		$display("test tx len %0d short %0b done", len, sh);
	endtask : t_tx
	task automatic t_rx(input logic ex, input logic [31:0] code, input logic [31:0] sig,
		input logic [3:0] win, input logic e_ok, input logic e_rep, input logic [31:0] e_store);
		int k;
		wait_ready();
		rx_expl <= ex;
		rx_rlc <= code;
		rx_sig <= sig;
		window <= win;
		rx_check <= 1'b1;
		@(posedge clk);
		rx_check <= 1'b0;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ok !== 1'b1 && fail !== 1'b1 && k < 300);
		if (k >= 300) give_up("rx check");
		check(ok, e_ok, "auth ok");
		check(fail, !e_ok, "auth fail");
		check(replay, e_rep, "replay");
		@(posedge clk);
		check(rx_rlc_q, e_store, "stored code");
		$display("test rx code %h done", code);
	endtask : t_rx
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{arst_n, tx_start, short_f, pay_valid, rlc_load, slow, rx_check, rx_expl} = 8'h00;
		{tx_len, pay_data, rx_sig, rx_rlc, window} = '0;
		dest = 32'h0a0b_0c0d;
		src = 32'hf1e2_d3c4;
		status = 8'h5c;
		radio_telegram_type = 8'hd2;
		chain_id = 2'h2;
		rlc_tx_init = 32'h0000_00fe;
		rlc_rx_init = 32'h0000_0100;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rlc_load <= 1'b1;
		@(posedge clk);
		rlc_load <= 1'b0;
		t_tx(7, 1'b0, 1'b0);
		t_tx(13, 1'b1, 1'b1);
		t_tx(5, 1'b0, 1'b1);
		t_tx(12, 1'b1, 1'b0);
		t_rx(1'b1, 32'h105, sig_f(32'h105), 4'h1, 1'b1, 1'b0, 32'h105);
		t_rx(1'b1, 32'h105, sig_f(32'h105), 4'h1, 1'b0, 1'b1, 32'h105);
		t_rx(1'b1, 32'h107, sig_f(32'h107) ^ 32'h1, 4'h1, 1'b0, 1'b0, 32'h105);
		slow <= 1'b1;
		t_rx(1'b0, 32'h0, sig_f(32'h108), 4'h4, 1'b1, 1'b0, 32'h108);
		t_rx(1'b0, 32'h0, sig_f(32'h10b), 4'h2, 1'b0, 1'b0, 32'h108);
		t_rx(1'b0, 32'h0, sig_f(32'h109), 4'h0, 1'b1, 1'b0, 32'h109);
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
